/* File: rtl/rssp_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-wire bus with pull-ups: a line is low while any party drives it low.
interface rssp_bus_if;
   logic scl_host_o;
   logic scl_host_oe;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic scl;
   logic sda;

   // Wired-AND line levels.
   assign scl = !(scl_host_oe && !scl_host_o);
   assign sda = !(sda_host_oe && !sda_host_o) && !(sda_dev_oe && !sda_dev_o);

   modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
   modport host (output scl_host_o, output scl_host_oe, output sda_host_o,
                 output sda_host_oe, input scl, input sda);
endinterface
`default_nettype wire

/* File: rtl/rssp_device.sv */
// Behaviour
// - Device is slave; master clocks everything.
// - Bytes shift most significant bit first.
// - Data changes only while clock low.
// - Watch for START; ignore bus until then.
// - Ignore START during power-up; release data.
// - STOP ends operation; device goes standby.
// - Transmitter releases; receiver acks ninth clock.
// - Ack slave byte, address, written data.
// - Master acks each read byte for more.
// - Two identifiers: register space, user memory.
// - Slave byte bit zero: one read.
// - Ack only when an identifier matches.
// - Address from master or internal counter.
// - Address counter clears to zero at power-up.
// - Random read reuses same slave identifier.
// - Write: START, slave, address, data, STOP.
// - User memory holds 128 bytes, 00h-7Fh.
// - Turnover code five bits; upper bits zero.
// - Presets load at power-up; software may overwrite.
// - Hot curvature at 2Dh, seven-bit magnitude.
// - Change hot curvature only with sensing off; there is no sensing here, and writes to 2Dh take effect at any time.
// - Keep sending while master acknowledges.
// - Register pointer wraps 2Fh to 00h.
`timescale 1ns/1ps
`default_nettype none
module rssp_device (
   input wire logic clk_sys,
   input wire logic rst_n,
   rssp_bus_if.dev bus,
   output logic powered_up,
   output logic [4:0] turnover_temp_code,
   output logic [6:0] hot_coeff_magnitude
);
   import rssp_pkg::*;

   // --------------------------------------------------------------------
   // State
   // --------------------------------------------------------------------
   typedef struct packed {
      rssp_dev_st_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic sel_mem;
      logic rw;
      logic drv_low;
      logic [7:0] pwr_cnt;
      logic pwr_done;
      logic [4:0] turnover;
      logic [6:0] hot_coeff;
      logic [MEM_DEPTH-1:0][7:0] mem;
   } rssp_dev_state_t;

   rssp_dev_state_t s;
   rssp_dev_state_t n;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic sda_smp;
   logic [7:0] rd_byte;

   // --------------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------------
   // Next pointer value; each space wraps at its own last location.
   function automatic logic [7:0] rssp_next_ptr(input logic [7:0] p, input logic mem_sel);
      logic [7:0] r;
      r = p + 8'h01;
      if (mem_sel) begin
         r = {1'b0, p[6:0] + 7'h01};
      end else if (p >= REG_LAST_ADDR) begin
         r = 8'h00;
      end
      return r;
   endfunction

   // Byte seen by a read at the current pointer.
   function automatic logic [7:0] rssp_read_byte(input rssp_dev_state_t q);
      logic [7:0] r;
      r = 8'h00;
      if (q.sel_mem) begin
         r = q.mem[q.ptr[6:0]];
      end else if (q.ptr == REG_CRYSTAL_TURNOVER_TEMP) begin
         r = {3'h0, q.turnover};
      end else if (q.ptr == REG_HOT_CURVATURE_COEFF) begin
         r = {1'b0, q.hot_coeff};
      end
      return r;
   endfunction

   // --------------------------------------------------------------------
   // Line events
   // --------------------------------------------------------------------
   rssp_edge_det rssp_edge_det_inst (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .scl_in(bus.scl),
      .sda_in(bus.sda),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start_det(start_det),
      .stop_det(stop_det),
      .sda_smp(sda_smp)
   );

   assign rd_byte = rssp_read_byte(s);

   // --------------------------------------------------------------------
   // Protocol engine
   // --------------------------------------------------------------------
   // One update per event; the data line only moves after a clock fall.
   always_comb begin
      n = s;
      if (!s.pwr_done) begin
         n.drv_low = 1'b0;
         if (s.pwr_cnt == PWRUP_CNT_LAST) begin
            n.pwr_done = 1'b1;
         end else begin
            n.pwr_cnt = s.pwr_cnt + 8'h01;
         end
      end else if (start_det) begin
         n.st = DST_SLAVE;
         n.cnt = 4'h0;
         n.drv_low = 1'b0;
      end else if (stop_det) begin
         n.st = DST_IDLE;
         n.drv_low = 1'b0;
      end else begin
         case (s.st)
            DST_SLAVE, DST_WADDR, DST_WDATA: begin
               if (scl_rise && s.cnt < BITS_PER_BYTE) begin
                  n.sh = {s.sh[6:0], sda_smp};
                  n.cnt = s.cnt + 4'h1;
               end else if (scl_fall && s.cnt == BITS_PER_BYTE) begin
                  n.cnt = 4'h0;
                  n.drv_low = 1'b1;
                  n.st = DST_WACK;
                  if (s.st == DST_SLAVE) begin
                     if (s.sh[7:1] == ID_REG_SPACE || s.sh[7:1] == ID_MEM_SPACE) begin
                        n.sel_mem = (s.sh[7:1] == ID_MEM_SPACE);
                        n.rw = s.sh[0];
                        n.st = DST_SACK;
                     end else begin
                        n.drv_low = 1'b0;
                        n.st = DST_IDLE;
                     end
                  end else if (s.st == DST_WADDR) begin
                     n.ptr = s.sh;
                  end else begin
                     if (s.sel_mem) begin
                        n.mem[s.ptr[6:0]] = s.sh;
                     end else if (s.ptr == REG_CRYSTAL_TURNOVER_TEMP) begin
                        n.turnover = s.sh[4:0];
                     end else if (s.ptr == REG_HOT_CURVATURE_COEFF) begin
                        n.hot_coeff = s.sh[6:0];
                     end
                     n.ptr = rssp_next_ptr(s.ptr, s.sel_mem);
                  end
               end
            end
            DST_SACK, DST_WACK: begin
               if (scl_fall) begin
                  n.drv_low = 1'b0;
                  n.st = DST_WDATA;
                  if (s.st == DST_SACK && s.rw) begin
                     n.sh = rd_byte;
                     n.drv_low = !rd_byte[7];
                     n.st = DST_RDATA;
                  end else if (s.st == DST_SACK) begin
                     n.st = DST_WADDR;
                  end
               end
            end
            DST_RDATA: begin
               if (scl_rise) begin
                  n.cnt = s.cnt + 4'h1;
               end else if (scl_fall && s.cnt == BITS_PER_BYTE) begin
                  n.drv_low = 1'b0;
                  n.cnt = 4'h0;
                  n.ptr = rssp_next_ptr(s.ptr, s.sel_mem);
                  n.st = DST_RACK;
               end else if (scl_fall) begin
                  n.sh = {s.sh[6:0], 1'b0};
                  n.drv_low = !s.sh[6];
               end
            end
            DST_RACK: begin
               if (scl_rise && sda_smp) begin
                  n.st = DST_IDLE;
               end else if (scl_fall) begin
                  n.sh = rd_byte;
                  n.drv_low = !rd_byte[7];
                  n.st = DST_RDATA;
               end
            end
            default: begin
               n.drv_low = 1'b0;
            end
         endcase
      end
   end

   // Power-up clears the pointer and recalls the presets.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s <= '0;
         s.st <= DST_IDLE;
         s.ptr <= 8'h00;
         s.turnover <= TURNOVER_RESET;
         s.hot_coeff <= HOT_COEFF_PRESET;
      end else begin
         s <= n;
      end
   end

   // --------------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------------
   // only ever sinks the data line.
   assign bus.sda_dev_o = 1'b0;
   assign bus.sda_dev_oe = s.drv_low;
   assign powered_up = s.pwr_done;
   assign turnover_temp_code = s.turnover;
   assign hot_coeff_magnitude = s.hot_coeff;
endmodule // rssp_device
`default_nettype wire

/* File: rtl/rssp_edge_det.sv */
`timescale 1ns/1ps
`default_nettype none
module rssp_edge_det (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_rise,
   output logic scl_fall,
   output logic start_det,
   output logic stop_det,
   output logic sda_smp
);
   typedef struct packed {
      logic scl;
      logic sda;
      logic rise;
      logic fall;
      logic start;
      logic stop;
      logic smp;
   } rssp_edge_state_t;

   rssp_edge_state_t s;
   rssp_edge_state_t n;

   // Compare the lines with their previous levels.
   always_comb begin
      n = s;
      n.scl = scl_in;
      n.sda = sda_in;
      n.smp = sda_in;
      n.rise = !s.scl && scl_in;
      n.fall = s.scl && !scl_in;
      n.start = s.scl && scl_in && s.sda && !sda_in;
      n.stop = s.scl && scl_in && !s.sda && sda_in;
   end

   // Lines idle high, so the history starts high.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s <= '0;
         s.scl <= 1'b1;
         s.sda <= 1'b1;
         s.smp <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // Registered line events, one cycle each.
   assign scl_rise = s.rise;
   assign scl_fall = s.fall;
   assign start_det = s.start;
   assign stop_det = s.stop;
   assign sda_smp = s.smp;
endmodule // rssp_edge_det
`default_nettype wire

/* File: rtl/rssp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module rssp_host (
   input wire logic clk_sys,
   input wire logic rst_n,
   rssp_bus_if.host bus,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata
);
   import rssp_pkg::*;

   // --------------------------------------------------------------------
   // State
   // --------------------------------------------------------------------
   typedef struct packed {
      rssp_host_st_t st;
      logic [6:0] qcnt;
      logic [1:0] q;
      logic [3:0] idx;
      logic [7:0] txd;
      logic [7:0] tx;
      logic [7:0] rx;
      logic do_stop;
      logic do_read;
      logic do_nack;
      logic ack_seen;
      logic scl_lvl;
      logic sda_lvl;
      logic [7:0] rdata;
   } rssp_host_state_t;

   rssp_host_state_t s;
   rssp_host_state_t n;
   logic tick;

   // Quarter-bit tick from the divider.
   assign tick = (s.qcnt == SCL_QTR_LAST);

   // --------------------------------------------------------------------
   // Register port and bus sequencer
   // --------------------------------------------------------------------
   // Each bit takes four quarter ticks: set data, raise, sample, lower.
   always_comb begin
      n = s;
      n.rdata = 8'h00;
      if (reg_rd) begin
         if (reg_addr == HOST_TXD_OFS) begin
            n.rdata = s.txd;
         end else if (reg_addr == HOST_RXD_OFS) begin
            n.rdata = s.rx;
         end else if (reg_addr == HOST_STAT_OFS) begin
            n.rdata[STAT_BUSY_BIT] = (s.st != HST_IDLE);
            n.rdata[STAT_ACK_BIT] = s.ack_seen;
         end
      end
      if (reg_wr && reg_addr == HOST_TXD_OFS) begin
         n.txd = reg_wdata;
      end
      if (s.st == HST_IDLE) begin
         n.qcnt = 7'h00;
         n.q = 2'h0;
         if (reg_wr && reg_addr == HOST_CTRL_OFS) begin
            n.do_stop = reg_wdata[CTRL_STOP_BIT];
            n.do_read = reg_wdata[CTRL_READ_BIT];
            n.do_nack = reg_wdata[CTRL_NACK_BIT];
            n.tx = s.txd;
            n.idx = 4'h0;
            n.st = reg_wdata[CTRL_START_BIT] ? HST_START : HST_BIT;
         end
      end else begin
         n.qcnt = tick ? 7'h00 : s.qcnt + 7'h01;
         if (tick) begin
            n.q = s.q + 2'h1;
            case (s.st)
               HST_START: begin
                  case (s.q)
                     2'h0: n.sda_lvl = 1'b1;
                     2'h1: n.scl_lvl = 1'b1;
                     2'h2: n.sda_lvl = 1'b0;
                     default: begin
                        n.scl_lvl = 1'b0;
                        n.st = HST_BIT;
                     end
                  endcase
               end
               HST_BIT: begin
                  case (s.q)
                     2'h0: begin
                        if (s.idx < BITS_PER_BYTE) begin
                           n.sda_lvl = s.do_read ? 1'b1 : s.tx[7];
                        end else begin
                           n.sda_lvl = s.do_read ? s.do_nack : 1'b1;
                        end
                     end
                     2'h1: n.scl_lvl = 1'b1;
                     2'h2: begin
                        if (s.idx < BITS_PER_BYTE) begin
                           n.rx = {s.rx[6:0], bus.sda};
                        end else begin
                           n.ack_seen = !bus.sda;
                        end
                     end
                     default: begin
                        n.scl_lvl = 1'b0;
                        n.tx = {s.tx[6:0], 1'b0};
                        n.idx = s.idx + 4'h1;
                        if (s.idx == BITS_PER_BYTE) begin
                           n.sda_lvl = 1'b1;
                           n.st = s.do_stop ? HST_STOP : HST_IDLE;
                        end
                     end
                  endcase
               end
               HST_STOP: begin
                  case (s.q)
                     2'h0: n.sda_lvl = 1'b0;
                     2'h1: n.scl_lvl = 1'b1;
                     2'h2: n.sda_lvl = 1'b1;
                     default: n.st = HST_IDLE;
                  endcase
               end
               default: n.st = HST_IDLE;
            endcase
         end
      end
   end

   // Lines rest released.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s <= '0;
         s.st <= HST_IDLE;
         s.scl_lvl <= 1'b1;
         s.sda_lvl <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // --------------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------------
   // Open-drain: drive only low levels.
   assign bus.scl_host_o = 1'b0;
   assign bus.scl_host_oe = !s.scl_lvl;
   assign bus.sda_host_o = 1'b0;
   assign bus.sda_host_oe = !s.sda_lvl;
   assign reg_rdata = s.rdata;
endmodule // rssp_host
`default_nettype wire

/* File: rtl/rssp_pkg.sv */
`default_nettype none
package rssp_pkg;
   // --------------------------------------------------------------------
   // Clock and timing
   // --------------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 200;
   // Power-up sequence length in nanoseconds, rounded up to cycles.
   localparam int unsigned PWRUP_NS = 1000;
   localparam int unsigned PWRUP_CYCLES = (PWRUP_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] PWRUP_CNT_LAST = 8'(PWRUP_CYCLES - 1);
   // Serial clock rate of the host, one quarter period per tick.
   localparam int unsigned SCL_KHZ = 400;
   localparam int unsigned SCL_QTR_CYCLES = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
   localparam logic [6:0] SCL_QTR_LAST = 7'(SCL_QTR_CYCLES - 1);
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // --------------------------------------------------------------------
   // Device identifiers (values are arbitrary)
   // --------------------------------------------------------------------
   localparam logic [6:0] ID_REG_SPACE = 7'h2A;
   localparam logic [6:0] ID_MEM_SPACE = 7'h35;

   // --------------------------------------------------------------------
   // Device register space
   // --------------------------------------------------------------------
   localparam logic [7:0] REG_CRYSTAL_TURNOVER_TEMP = 8'h2C;
   localparam logic [7:0] REG_HOT_CURVATURE_COEFF = 8'h2D;
   localparam logic [7:0] REG_LAST_ADDR = 8'h2F;
   localparam logic [6:0] MEM_LAST_ADDR = 7'h7F;
   localparam int unsigned MEM_DEPTH = 128;
   localparam logic [4:0] TURNOVER_RESET = 5'h00;
   localparam logic [6:0] HOT_COEFF_PRESET = 7'h46;

   // --------------------------------------------------------------------
   // Host command registers
   // --------------------------------------------------------------------
   localparam logic [7:0] HOST_CTRL_OFS = 8'h00;
   localparam logic [7:0] HOST_TXD_OFS = 8'h04;
   localparam logic [7:0] HOST_RXD_OFS = 8'h08;
   localparam logic [7:0] HOST_STAT_OFS = 8'h0C;
   localparam int unsigned CTRL_START_BIT = 0;
   localparam int unsigned CTRL_STOP_BIT = 1;
   localparam int unsigned CTRL_READ_BIT = 2;
   localparam int unsigned CTRL_NACK_BIT = 3;
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_ACK_BIT = 1;

   // --------------------------------------------------------------------
   // State encodings
   // --------------------------------------------------------------------
   typedef enum logic [8:0] {
      DST_IDLE = 9'h001,
      DST_SLAVE = 9'h002,
      DST_SACK = 9'h004,
      DST_WADDR = 9'h008,
      DST_WACK = 9'h010,
      DST_WDATA = 9'h020,
      DST_RDATA = 9'h040,
      DST_RACK = 9'h080,
      DST_SPARE = 9'h100
   } rssp_dev_st_t;

   typedef enum logic [3:0] {
      HST_IDLE = 4'h1,
      HST_START = 4'h2,
      HST_BIT = 4'h4,
      HST_STOP = 4'h8
   } rssp_host_st_t;
endpackage
`default_nettype wire

/* File: tb/rssp_bus_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Wire-level watcher of the two-wire bus between both ends
// ------------------------------------------------------------
module rssp_bus_monitor (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sda,
   input wire logic scl_host_oe,
   input wire logic sda_host_oe,
   input wire logic sda_dev_oe
);
   logic sda_q;
   logic started_r;

   default clocking mon_cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // Remembers whether any START has been seen since reset.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sda_q <= 1'b1;
         started_r <= 1'b0;
      end else begin
         sda_q <= sda;
         if (scl && sda_q && !sda) begin
            started_r <= 1'b1;
         end
      end
   end

   reset_lines_free_a: assert property ($rose(rst_n) |->
      !sda_dev_oe && !sda_host_oe && !scl_host_oe)
      else $error("bus not released after reset");
   dev_change_low_a: assert property ($changed(sda_dev_oe) |-> !scl && !$past(scl))
      else $error("device moved data while clock high");
   dev_after_start_a: assert property (sda_dev_oe |-> started_r)
      else $error("device drove data before any start");
   clock_high_hold_a: assert property ($rose(scl) |=> scl [*8])
      else $error("serial clock high phase too short");
   start_hold_a: assert property ($fell(sda) && scl |=> scl [*8])
      else $error("clock dropped right after start");
   stop_released_a: assert property ($rose(sda) && scl |=> !sda_dev_oe [*8])
      else $error("device drove data after stop");
   ack_steady_a: assert property ($rose(scl) && sda_dev_oe |=> (sda_dev_oe && !sda) [*8])
      else $error("device low level not held over clock high");
   host_released_a: assert property (sda_dev_oe && scl |-> !sda_host_oe)
      else $error("host drove data while device transmits");

   start_seen_c: cover property ($fell(sda) && scl);
   stop_seen_c: cover property ($rose(sda) && scl);
   dev_drive_c: cover property ($rose(sda_dev_oe));
endmodule // rssp_bus_monitor
`default_nettype wire

/* File: tb/rtc_serial_slave_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Bench: host end and device end joined over one bus
// ------------------------------------------------------------
module rtc_serial_slave_port_test;
   import rssp_pkg::*;
   localparam logic [7:0] C_S = 8'h01;
   localparam logic [7:0] C_P = 8'h02;
   localparam logic [7:0] C_R = 8'h04;
   localparam logic [7:0] C_N = 8'h08;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic powered_up;
   logic [4:0] turnover_temp_code;
   logic [6:0] hot_coeff_magnitude;
   int failures = 0;
   int total_checks = 0;
   int seed = 32'h55E6;
   logic [7:0] exp_q[$];
   logic [7:0] msk_q[$];
   logic rd_d = 1'b0;
   logic [7:0] v, m_w, e_w, d0, d1, d2;

   // Free-running system clock.
   always #2.5 clk_sys = ~clk_sys;

   rssp_bus_if rssp_bus_if_inst();
   rssp_device rssp_device_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus(rssp_bus_if_inst),
      .powered_up(powered_up), .turnover_temp_code(turnover_temp_code),
      .hot_coeff_magnitude(hot_coeff_magnitude));
   rssp_host rssp_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus(rssp_bus_if_inst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   rssp_bus_monitor rssp_bus_monitor_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .scl(rssp_bus_if_inst.scl), .sda(rssp_bus_if_inst.sda),
      .scl_host_oe(rssp_bus_if_inst.scl_host_oe), .sda_host_oe(rssp_bus_if_inst.sda_host_oe),
      .sda_dev_oe(rssp_bus_if_inst.sda_dev_oe));

   // ------------------------------------------------------------
   // Reporting and register port tasks
   // ------------------------------------------------------------
   task automatic give_verdict;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // A zero mask marks a read whose result is not compared.
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk_sys);
      exp_q.push_back(e);
      msk_q.push_back(m);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   // One byte on the bus; checks received data or the acknowledge flag.
   task automatic op(input logic [7:0] tx, input logic [7:0] ctl, input logic [7:0] e,
                     input logic [7:0] m, input logic ak);
      int n;
      wr(HOST_TXD_OFS, tx);
      wr(HOST_CTRL_OFS, ctl);
      n = 0;
      v = 8'h01;
      while (v[STAT_BUSY_BIT] !== 1'b0 && n < 5000) begin
         rd(HOST_STAT_OFS, 8'h00, 8'h00);
         n++;
      end
      if (n == 5000) begin
         failures++;
         $display("ERROR at %0t: bus stayed busy", $time);
         give_verdict();
      end
      if (m != 8'h00) begin
         rd(HOST_RXD_OFS, e, m);
      end else begin
         rd(HOST_STAT_OFS, {6'h00, ak, 1'b0}, 8'h02);
      end
   endtask

   // Compares each noted read result in the cycle its data stands.
   always @(posedge clk_sys) begin
      if (rd_d) begin
         m_w = msk_q.pop_front();
         e_w = exp_q.pop_front();
         if (m_w != 8'h00) begin
            chk(reg_rdata & m_w, e_w);
         end
      end
      rd_d <= reg_rd;
   end

   // Cuts a hung run short.
   initial begin
      repeat (99000) @(posedge clk_sys);
      failures++;
      $display("ERROR at %0t: run timed out", $time);
      give_verdict();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      int k;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      k = 0;
      while (powered_up !== 1'b1 && k < 400) begin
         @(posedge clk_sys);
         k++;
      end
      if (k == 400) begin
         failures++;
         $display("ERROR at %0t: power-up never finished", $time);
         give_verdict();
      end
      d0 = 8'($random(seed));
      d1 = 8'($random(seed));
      d2 = 8'($random(seed));
      chk({1'b0, hot_coeff_magnitude}, {1'b0, HOT_COEFF_PRESET});
      chk({3'h0, turnover_temp_code}, {3'h0, TURNOVER_RESET});
      op({ID_REG_SPACE, 1'b0}, C_S, 8'h00, 8'h00, 1'b1);
      op(REG_CRYSTAL_TURNOVER_TEMP, 8'h00, 8'h00, 8'h00, 1'b1);
      op(d0, C_P, 8'h00, 8'h00, 1'b1);
      chk({3'h0, turnover_temp_code}, {3'h0, d0[4:0]});
      op({ID_REG_SPACE, 1'b0}, C_S, 8'h00, 8'h00, 1'b1);
      op(REG_CRYSTAL_TURNOVER_TEMP, 8'h00, 8'h00, 8'h00, 1'b1);
      op({ID_REG_SPACE, 1'b1}, C_S, 8'h00, 8'h00, 1'b1);
      op(8'hFF, C_R, {3'h0, d0[4:0]}, 8'hFF, 1'b0);
      op(8'hFF, C_R | C_N | C_P, {1'b0, HOT_COEFF_PRESET}, 8'hFF, 1'b0);
      op({7'h11, 1'b0}, C_S | C_P, 8'h00, 8'h00, 1'b0);
      op({ID_MEM_SPACE, 1'b0}, C_S, 8'h00, 8'h00, 1'b1);
      op({1'b0, MEM_LAST_ADDR}, 8'h00, 8'h00, 8'h00, 1'b1);
      op(d1, 8'h00, 8'h00, 8'h00, 1'b1);
      op(d2, C_P, 8'h00, 8'h00, 1'b1);
      op({ID_MEM_SPACE, 1'b0}, C_S, 8'h00, 8'h00, 1'b1);
      op({1'b0, MEM_LAST_ADDR}, 8'h00, 8'h00, 8'h00, 1'b1);
      op({ID_MEM_SPACE, 1'b1}, C_S, 8'h00, 8'h00, 1'b1);
      op(8'hFF, C_R, d1, 8'hFF, 1'b0);
      op(8'hFF, C_R | C_N | C_P, d2, 8'hFF, 1'b0);
      repeat (4) @(posedge clk_sys);
      give_verdict();
   end
endmodule // rtc_serial_slave_port_test
`default_nettype wire
